// file: hw/lbm_pkg.sv
// Function
// - The long call is opcode 12h, three bytes, two cycles, and continues at the target formed from byte two (high) and byte three (low).
// - The long call pushes program counter plus three, low byte at stack pointer plus one and high byte at plus two, leaving the stack pointer two higher.
// - Long call and long jump reach any address in the 64K program space and change no status flag.
// - The long jump is opcode 02h, three bytes, one cycle, and loads the program counter high byte from byte two and low byte from byte three.
// - A byte move copies source to destination, leaving the source and every other register and flag untouched.
// - Work register destinations decode as E8h+r, E5h, E6h+i and 74h.
// - Bank register destinations decode as F8h+r, A8h+r, 78h+r and indirect destinations as F6h+i, A6h+i, 76h+i.
// - Direct destinations decode as F5h, 88h+r, 86h+i, 85h (source address first) and 75h (address before data).
// - The direct-to-work-register form naming the work register itself is invalid and gets no defined move.
// - A bit move copies between the carry flag and any directly addressable bit and changes nothing else.
// - Fields r and i pick R0-R7 or R0-R1 of the current bank, and indirect forms use that register as a RAM address.
package lbm_pkg;

  // ==========================================================================
  // Opcodes and decode masks
  localparam logic [7:0] OPC_CALL     = 8'h12;
  localparam logic [7:0] OPC_JUMP     = 8'h02;
  localparam logic [7:0] OPC_A_REG    = 8'he8;
  localparam logic [7:0] OPC_A_DIR    = 8'he5;
  localparam logic [7:0] OPC_A_IND    = 8'he6;
  localparam logic [7:0] OPC_A_IMM    = 8'h74;
  localparam logic [7:0] OPC_R_A      = 8'hf8;
  localparam logic [7:0] OPC_R_DIR    = 8'ha8;
  localparam logic [7:0] OPC_R_IMM    = 8'h78;
  localparam logic [7:0] OPC_I_A      = 8'hf6;
  localparam logic [7:0] OPC_I_DIR    = 8'ha6;
  localparam logic [7:0] OPC_I_IMM    = 8'h76;
  localparam logic [7:0] OPC_D_A      = 8'hf5;
  localparam logic [7:0] OPC_D_REG    = 8'h88;
  localparam logic [7:0] OPC_D_IND    = 8'h86;
  localparam logic [7:0] OPC_D_DIR    = 8'h85;
  localparam logic [7:0] OPC_D_IMM    = 8'h75;
  localparam logic [7:0] MASK_REG     = 8'hf8;
  localparam logic [7:0] MASK_IND     = 8'hfe;

  // ==========================================================================
  // Address map and arithmetic constants
  localparam logic [7:0]  WORK_REG_ADDR = 8'he0;
  localparam logic [7:0]  BIT_RAM_BASE  = 8'h20;
  localparam logic [7:0]  BIT_SFR_START = 8'h80;
  localparam logic [15:0] RET_OFFSET    = 16'h0003;
  localparam logic [7:0]  PUSH_STEP     = 8'h01;
  localparam logic [7:0]  PUSH_TOTAL    = 8'h02;
  localparam logic [1:0]  LEN_1         = 2'h1;
  localparam logic [1:0]  LEN_2         = 2'h2;
  localparam logic [1:0]  LEN_3         = 2'h3;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PTR  = 3'b001,
    ST_SRC  = 3'b010,
    ST_WR   = 3'b011,
    ST_PUSH = 3'b100
  } lbm_state_e;

  typedef enum logic [1:0] {
    K_NONE = 2'b00,
    K_MOVE = 2'b01,
    K_CALL = 2'b10,
    K_JUMP = 2'b11
  } lbm_kind_e;

  typedef enum logic [2:0] {
    OPD_NONE = 3'b000,
    OPD_ACC  = 3'b001,
    OPD_IMM  = 3'b010,
    OPD_DIR  = 3'b011,
    OPD_REG  = 3'b100,
    OPD_IND  = 3'b101
  } lbm_opd_e;

  typedef struct packed {
    lbm_kind_e  kind;
    lbm_opd_e   src;
    lbm_opd_e   dst;
    logic       imm_b3;   // Immediate sits in byte three
    logic       dst_b3;   // Destination address sits in byte three
    logic [1:0] len;
  } lbm_dec_s;

endpackage : lbm_pkg

// file: hw/lbm_dec_if.sv
`timescale 1ns/1ps
// ============================================================================
// Opcode in, decoded operation out
interface lbm_dec_if;
  import lbm_pkg::*;
  logic [7:0] opcode;
  logic [7:0] byte2;
  lbm_dec_s   dec;
  logic       invalid;

  modport client  (output opcode, output byte2, input dec, input invalid);
  modport decoder (input opcode, input byte2, output dec, output invalid);
endinterface : lbm_dec_if

// file: hw/lbm_decode.sv
`timescale 1ns/1ps
// ============================================================================
// Combinational opcode decoder
module lbm_decode (
  lbm_dec_if.decoder dif
);
  import lbm_pkg::*;

  // Builds one decode entry
  function automatic lbm_dec_s mk(lbm_kind_e k, lbm_opd_e s, lbm_opd_e d,
                                  logic [1:0] n);
    lbm_dec_s r;
    r.kind   = k;
    r.src    = s;
    r.dst    = d;
    r.imm_b3 = 1'b0;
    r.dst_b3 = 1'b0;
    r.len    = n;
    return r;
  endfunction : mk

  // ==========================================================================
  // Opcode table; anything unlisted belongs to other units
  always_comb begin
    lbm_dec_s d;
    d = mk(K_NONE, OPD_NONE, OPD_NONE, LEN_1);
    if (dif.opcode == OPC_CALL) d = mk(K_CALL, OPD_NONE, OPD_NONE, LEN_3);
    if (dif.opcode == OPC_JUMP) d = mk(K_JUMP, OPD_NONE, OPD_NONE, LEN_3);
    if ((dif.opcode & MASK_REG) == OPC_A_REG) d = mk(K_MOVE, OPD_REG, OPD_ACC, LEN_1);
    if (dif.opcode == OPC_A_DIR) d = mk(K_MOVE, OPD_DIR, OPD_ACC, LEN_2);
    if ((dif.opcode & MASK_IND) == OPC_A_IND) d = mk(K_MOVE, OPD_IND, OPD_ACC, LEN_1);
    if (dif.opcode == OPC_A_IMM) d = mk(K_MOVE, OPD_IMM, OPD_ACC, LEN_2);
    if ((dif.opcode & MASK_REG) == OPC_R_A) d = mk(K_MOVE, OPD_ACC, OPD_REG, LEN_1);
    if ((dif.opcode & MASK_REG) == OPC_R_DIR) d = mk(K_MOVE, OPD_DIR, OPD_REG, LEN_2);
    if ((dif.opcode & MASK_REG) == OPC_R_IMM) d = mk(K_MOVE, OPD_IMM, OPD_REG, LEN_2);
    if ((dif.opcode & MASK_IND) == OPC_I_A) d = mk(K_MOVE, OPD_ACC, OPD_IND, LEN_1);
    if ((dif.opcode & MASK_IND) == OPC_I_DIR) d = mk(K_MOVE, OPD_DIR, OPD_IND, LEN_2);
    if ((dif.opcode & MASK_IND) == OPC_I_IMM) d = mk(K_MOVE, OPD_IMM, OPD_IND, LEN_2);
    if (dif.opcode == OPC_D_A) d = mk(K_MOVE, OPD_ACC, OPD_DIR, LEN_2);
    if ((dif.opcode & MASK_REG) == OPC_D_REG) d = mk(K_MOVE, OPD_REG, OPD_DIR, LEN_2);
    if ((dif.opcode & MASK_IND) == OPC_D_IND) d = mk(K_MOVE, OPD_IND, OPD_DIR, LEN_2);
    if (dif.opcode == OPC_D_DIR) begin
      d = mk(K_MOVE, OPD_DIR, OPD_DIR, LEN_3);
      d.dst_b3 = 1'b1;                         // Source address comes first
    end
    if (dif.opcode == OPC_D_IMM) begin
      d = mk(K_MOVE, OPD_IMM, OPD_DIR, LEN_3);
      d.imm_b3 = 1'b1;                         // Address before data
    end
    dif.dec = d;
    // Work register read onto itself has no defined move
    dif.invalid = (dif.opcode == OPC_A_DIR) &&
                  (dif.byte2 == WORK_REG_ADDR);
  end

endmodule : lbm_decode

// file: hw/lbm_exec.sv
`timescale 1ns/1ps
// ============================================================================
// Long branch and byte/bit move execution unit
module lbm_exec #(
  parameter int PC_W = 16
) (
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  input  wire logic        i_op_valid,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [7:0]  i_byte2,
  input  wire logic [7:0]  i_byte3,
  input  wire logic [15:0] i_pc,
  input  wire logic [1:0]  i_bank_sel,
  input  wire logic [7:0]  i_stack_ptr,
  input  wire logic [7:0]  i_acc,
  input  wire logic        i_carry,
  input  wire logic        i_bit_valid,
  input  wire logic        i_bit_to_carry,
  input  wire logic [7:0]  i_bit_addr,
  input  wire logic [7:0]  i_ram_rdata,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_illegal,
  output logic [1:0]       o_instr_len,
  output logic             o_pc_load,
  output logic [15:0]      o_pc_value,
  output logic             o_sp_load,
  output logic [7:0]       o_sp_value,
  output logic             o_acc_load,
  output logic [7:0]       o_acc_value,
  output logic             o_carry_load,
  output logic             o_carry_value,
  output logic             o_ram_re,
  output logic             o_ram_we,
  output logic [7:0]       o_ram_addr,
  output logic [7:0]       o_ram_wdata
);
  import lbm_pkg::*;

  // The return arithmetic and the 64K reach assume a 16-bit counter
  if (PC_W != 16) begin : g_pc_check
    $error("lbm_exec supports only PC_W of 16");
  end

  // ==========================================================================
  // Address helpers
  function automatic logic [7:0] bank_addr(logic [1:0] bank,
                                           logic [2:0] idx);
    return {3'h0, bank, idx};
  endfunction : bank_addr

  // Bits below 80h live in RAM from 20h, the rest in 8-aligned registers
  function automatic logic [7:0] bit_byte(logic [7:0] a);
    if (a < BIT_SFR_START) return BIT_RAM_BASE + {4'h0, a[6:3]};
    return {a[7:3], 3'h0};
  endfunction : bit_byte

  // ==========================================================================
  // State
  typedef struct packed {
    lbm_state_e st;
    lbm_dec_s   dec;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [1:0] bank;
    logic [2:0] idx;
    logic       bit_op;
    logic       bit_to_c;
    logic [2:0] bit_pos;
    logic [7:0] data;
    logic [7:0] wr_addr;
    logic [7:0] sp;
    logic [15:0] ret;
    logic       busy;
    logic       done;
    logic       illegal;
    logic [1:0] len;
    logic       pc_load;
    logic [15:0] pc_value;
    logic       sp_load;
    logic [7:0] sp_value;
    logic       acc_load;
    logic [7:0] acc_value;
    logic       carry_load;
    logic       carry_value;
    logic       ram_re;
    logic       ram_we;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
  } lbm_exec_s;

  lbm_exec_s s_reg;
  lbm_exec_s s_next;

  lbm_dec_if dif ();
  assign dif.opcode = i_opcode;
  assign dif.byte2  = i_byte2;

  lbm_decode u_decode (
    .dif (dif)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    logic       take;
    logic [7:0] src_a;
    s_next = s_reg;
    take   = !s_reg.busy && (i_op_valid || i_bit_valid);
    src_a  = 8'h00;
    // Strobes last one cycle
    s_next.done       = 1'b0;
    s_next.illegal    = 1'b0;
    s_next.pc_load    = 1'b0;
    s_next.sp_load    = 1'b0;
    s_next.acc_load   = 1'b0;
    s_next.carry_load = 1'b0;
    s_next.ram_re     = 1'b0;
    s_next.ram_we     = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        s_next.busy = 1'b0;
        if (take && i_op_valid) begin
          s_next.dec   = dif.dec;
          s_next.byte2 = i_byte2;
          s_next.byte3 = i_byte3;
          s_next.bank  = i_bank_sel;
          s_next.idx   = i_opcode[2:0];
          s_next.bit_op = 1'b0;
          s_next.len   = dif.dec.len;
          s_next.sp    = i_stack_ptr;
          s_next.ret   = i_pc + RET_OFFSET;
          // Destination address for non-indirect stores
          s_next.wr_addr = dif.dec.dst_b3 ? i_byte3 :
                           (dif.dec.dst == OPD_REG) ?
                           bank_addr(i_bank_sel, i_opcode[2:0]) : i_byte2;
          s_next.data = (dif.dec.src == OPD_ACC) ? i_acc :
                        (dif.dec.imm_b3 ? i_byte3 : i_byte2);
          src_a = (dif.dec.src == OPD_REG) ?
                  bank_addr(i_bank_sel, i_opcode[2:0]) : i_byte2;
          if (dif.dec.kind == K_NONE || dif.invalid) begin
            s_next.illegal = 1'b1;
          end else if (dif.dec.kind == K_JUMP) begin
            // Flags are left to the core, none is touched here
            s_next.pc_load  = 1'b1;
            s_next.pc_value = {i_byte2, i_byte3};
            s_next.done     = 1'b1;
          end else if (dif.dec.kind == K_CALL) begin
            s_next.busy      = 1'b1;
            s_next.ram_we    = 1'b1;
            s_next.ram_addr  = i_stack_ptr + PUSH_STEP;
            s_next.ram_wdata = s_next.ret[7:0];
            s_next.st        = ST_PUSH;
          end else if (dif.dec.src == OPD_IND || dif.dec.dst == OPD_IND) begin
            // Pointer register is R0 or R1 of the current bank
            s_next.busy     = 1'b1;
            s_next.ram_re   = 1'b1;
            s_next.ram_addr = bank_addr(i_bank_sel, {2'h0, i_opcode[0]});
            s_next.st       = ST_PTR;
          end else if (dif.dec.src == OPD_DIR || dif.dec.src == OPD_REG) begin
            s_next.busy     = 1'b1;
            s_next.ram_re   = 1'b1;
            s_next.ram_addr = src_a;
            s_next.st       = ST_SRC;
          end else begin
            s_next.busy = 1'b1;
            s_next.st   = ST_WR;
          end
        end else if (take) begin
          // Bit move: read the holding byte first
          s_next.bit_op   = 1'b1;
          s_next.bit_to_c = i_bit_to_carry;
          s_next.bit_pos  = i_bit_addr[2:0];
          s_next.wr_addr  = bit_byte(i_bit_addr);
          s_next.dec.dst  = OPD_DIR;
          s_next.busy     = 1'b1;
          s_next.ram_re   = 1'b1;
          s_next.ram_addr = bit_byte(i_bit_addr);
          s_next.st       = ST_SRC;
        end
      end
      ST_PTR: begin
        // Indirect source reads through the pointer, else direct source
        if (s_reg.dec.dst == OPD_IND) s_next.wr_addr = i_ram_rdata;
        if (s_reg.dec.src == OPD_IND) begin
          s_next.ram_re   = 1'b1;
          s_next.ram_addr = i_ram_rdata;
          s_next.st       = ST_SRC;
        end else if (s_reg.dec.src == OPD_DIR) begin
          s_next.ram_re   = 1'b1;
          s_next.ram_addr = s_reg.byte2;
          s_next.st       = ST_SRC;
        end else begin
          s_next.st = ST_WR;
        end
      end
      ST_SRC: begin
        s_next.data = i_ram_rdata;
        if (s_reg.bit_op && s_reg.bit_to_c) begin
          s_next.carry_load  = 1'b1;
          s_next.carry_value = i_ram_rdata[s_reg.bit_pos];
          s_next.done        = 1'b1;
          s_next.busy        = 1'b0;
          s_next.st          = ST_IDLE;
        end else begin
          // Only the addressed bit changes in the byte written back
          if (s_reg.bit_op) s_next.data[s_reg.bit_pos] = i_carry;
          s_next.st = ST_WR;
        end
      end
      ST_WR: begin
        if (s_reg.dec.dst == OPD_ACC) begin
          s_next.acc_load  = 1'b1;
          s_next.acc_value = s_reg.data;
        end else begin
          s_next.ram_we    = 1'b1;
          s_next.ram_addr  = s_reg.wr_addr;
          s_next.ram_wdata = s_reg.data;
        end
        s_next.done = 1'b1;
        s_next.busy = 1'b0;
        s_next.st   = ST_IDLE;
      end
      ST_PUSH: begin
        // High byte second, stack pointer ends two higher
        s_next.ram_we    = 1'b1;
        s_next.ram_addr  = s_reg.sp + PUSH_TOTAL;
        s_next.ram_wdata = s_reg.ret[15:8];
        s_next.sp_load   = 1'b1;
        s_next.sp_value  = s_reg.sp + PUSH_TOTAL;
        s_next.pc_load   = 1'b1;
        s_next.pc_value  = {s_reg.byte2, s_reg.byte3};
        s_next.done      = 1'b1;
        s_next.busy      = 1'b0;
        s_next.st        = ST_IDLE;
      end
      default: begin
        s_next.busy = 1'b0;
        s_next.st   = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs straight from the state register
  assign o_busy        = s_reg.busy;
  assign o_done        = s_reg.done;
  assign o_illegal     = s_reg.illegal;
  assign o_instr_len   = s_reg.len;
  assign o_pc_load     = s_reg.pc_load;
  assign o_pc_value    = s_reg.pc_value;
  assign o_sp_load     = s_reg.sp_load;
  assign o_sp_value    = s_reg.sp_value;
  assign o_acc_load    = s_reg.acc_load;
  assign o_acc_value   = s_reg.acc_value;
  assign o_carry_load  = s_reg.carry_load;
  assign o_carry_value = s_reg.carry_value;
  assign o_ram_re      = s_reg.ram_re;
  assign o_ram_we      = s_reg.ram_we;
  assign o_ram_addr    = s_reg.ram_addr;
  assign o_ram_wdata   = s_reg.ram_wdata;

  // ==========================================================================
  // Checks
  sequence call_take_s;
    !o_busy && i_op_valid && i_opcode == OPC_CALL;
  endsequence
  sequence push_low_s;
    o_ram_we && o_ram_addr == $past(i_stack_ptr) + PUSH_STEP &&
    o_ram_wdata == 8'($past(i_pc) + RET_OFFSET);
  endsequence
  sequence push_high_s;
    o_ram_we && o_sp_load &&
    o_sp_value == $past(i_stack_ptr, 2) + PUSH_TOTAL;
  endsequence

  call_push_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    call_take_s |=> push_low_s ##1 push_high_s)
    else $error("call push order or address wrong");
  call_target_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    call_take_s |=> ##1 (o_pc_load && o_done &&
      o_pc_value == {$past(i_byte2, 2), $past(i_byte3, 2)}))
    else $error("call target not loaded");
  jump_load_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!o_busy && i_op_valid && i_opcode == OPC_JUMP) |=>
      (o_pc_load && !o_busy &&
       o_pc_value == {$past(i_byte2), $past(i_byte3)}))
    else $error("jump target not loaded");
  branch_flags_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_pc_load |-> !o_carry_load && !o_acc_load)
    else $error("branch touched a flag");
  move_only_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (o_acc_load || o_carry_load) |-> !o_pc_load && !o_sp_load && !o_ram_we)
    else $error("move touched another register");
  imm_acc_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!o_busy && i_op_valid && i_opcode == OPC_A_IMM) |=>
      ##1 (o_acc_load && o_acc_value == $past(i_byte2, 2)))
    else $error("immediate not copied to work register");
  bank_addr_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!o_busy && i_op_valid && (i_opcode & MASK_REG) == OPC_A_REG) |=>
      (o_ram_re &&
       o_ram_addr == {3'h0, $past(i_bank_sel), $past(i_opcode[2:0])}))
    else $error("bank register address wrong");
  acc_self_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!o_busy && i_op_valid && i_opcode == OPC_A_DIR &&
     i_byte2 == WORK_REG_ADDR) |=> (o_illegal && !o_ram_re && !o_busy))
    else $error("invalid form was executed");
  bit_carry_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!o_busy && !i_op_valid && i_bit_valid && i_bit_to_carry) |=>
      o_ram_re ##1 (o_carry_load && !o_ram_we))
    else $error("bit to carry sequence wrong");
  dir_dir_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!o_busy && i_op_valid && i_opcode == OPC_D_DIR) |=>
      (o_ram_addr == $past(i_byte2)) ##2
      (o_ram_we && o_ram_addr == $past(i_byte3, 3)))
    else $error("direct to direct order wrong");

endmodule : lbm_exec

// file: testbench/test_long_branch_and_byte_move_exec.sv
`timescale 1ns/1ps
// ============================================================================
// Self-checking bench for the long branch and byte/bit move unit
module test_long_branch_and_byte_move_exec;
  import lbm_pkg::*;
  logic        i_clock = 1'b0, i_sys_rst = 1'b1, op_v = 1'b0, bit_v = 1'b0;
  logic        to_c = 1'b0, carry = 1'b0;
  logic [7:0]  opc = 8'h00, b2 = 8'h00, b3 = 8'h00, sp = 8'h00, acc = 8'h00;
  logic [7:0]  baddr = 8'h00, rdata, spv, accv, addr, wdata;
  logic [15:0] pc = 16'h0000, pcv;
  logic [1:0]  bank = 2'h0, len;
  logic        busy, done, ill, pcl, spl, accl, cl, cv, re, we;
  logic [4:0]  strb;
  logic [7:0]  ram [256];
  int          n_mismatch = 0, n_checks = 0, n_we = 0, n_accl = 0, n_re = 0;
  int          cyc;

  lbm_exec dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_op_valid(op_v),
    .i_opcode(opc), .i_byte2(b2), .i_byte3(b3), .i_pc(pc),
    .i_bank_sel(bank), .i_stack_ptr(sp), .i_acc(acc), .i_carry(carry),
    .i_bit_valid(bit_v), .i_bit_to_carry(to_c), .i_bit_addr(baddr),
    .i_ram_rdata(rdata), .o_busy(busy), .o_done(done), .o_illegal(ill),
    .o_instr_len(len), .o_pc_load(pcl), .o_pc_value(pcv), .o_sp_load(spl),
    .o_sp_value(spv), .o_acc_load(accl), .o_acc_value(accv),
    .o_carry_load(cl), .o_carry_value(cv), .o_ram_re(re), .o_ram_we(we),
    .o_ram_addr(addr), .o_ram_wdata(wdata));

  // Clock at 40 MHz
  always #12.5 i_clock = ~i_clock;
  // RAM answers asynchronously, as the port expects
  assign rdata = ram[addr];
  // RAM image follows write strobes; strobe counts expose stray side effects
  always @(posedge i_clock) begin
    if (we) begin
      ram[addr] <= wdata;
      n_we <= n_we + 1;
    end
    if (accl) n_accl <= n_accl + 1;
    if (re) n_re <= n_re + 1;
  end

  // ==========================================================================
  // Shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait for completion; strobes are captured in the done cycle
  task automatic wait_end(input int ncyc);
    cyc = 1; // The take edge opens the first cycle
    while (done !== 1'b1 && ill !== 1'b1 && cyc < 12) begin
      @(posedge i_clock); #2;
      cyc++;
    end
    strb = {ill, pcl, spl, accl, cl};
    chk(cyc, ncyc);
    @(posedge i_clock); #2;
  endtask : wait_end

  task automatic run(input logic [7:0] o, x, y, input int ncyc);
    @(posedge i_clock); #2;
    opc = o; b2 = x; b3 = y; op_v = 1'b1; n_we = 0; n_accl = 0;
    n_re = 0;
    @(posedge i_clock); #2;
    op_v = 1'b0;
    wait_end(ncyc);
  endtask : run

  task automatic bitop(input logic [7:0] a, input logic t, c, input int n);
    @(posedge i_clock); #2;
    baddr = a; to_c = t; carry = c; bit_v = 1'b1; n_we = 0; n_accl = 0;
    n_re = 0;
    @(posedge i_clock); #2;
    bit_v = 1'b0;
    wait_end(n);
    chk(n_accl, 0);
    chk(n_re, 1);
  endtask : bitop

  // Move into RAM space: one write, work register untouched
  task automatic mv(input logic [7:0] o, x, y, input int n,
                    input logic [7:0] a, e);
    run(o, x, y, n);
    chk(ram[a], e);
    chk(n_we, 1);
    chk(n_accl, 0);
  endtask : mv

  // ==========================================================================
  // Scenarios
  task automatic t_branch;
    sp = 8'h07; pc = 16'h0123;
    run(OPC_CALL, 8'h12, 8'h34, 2);
    chk(pcv, 16'h1234);
    chk(len, LEN_3);
    chk(n_re, 0);
    chk(strb, 5'b01100);
    chk(spv, 8'h09);
    chk({ram[8], ram[9]}, 16'h2601);
    chk(n_we, 2);
    run(OPC_JUMP, 8'hff, 8'hfe, 1);
    chk(pcv, 16'hfffe);
    chk(len, LEN_3);
    chk(strb, 5'b01000);
    chk(n_we, 0);
    $display("branch test done");
  endtask : t_branch

  task automatic t_acc;
    bank = 2'h2;
    for (int r = 0; r < 8; r++) begin
      ram[8'h10 + r] = 8'h50 + r;
      run(OPC_A_REG | r, 8'h00, 8'h00, 3);
      chk(accv, 8'h50 + r);
      chk(strb, 5'b00010);
      chk(len, LEN_1);
    end
    ram[8'h10] = 8'h40; ram[8'h11] = 8'h41;
    ram[8'h40] = 8'h99; ram[8'h41] = 8'h77; ram[8'h35] = 8'ha5;
    run(OPC_A_IND, 8'h00, 8'h00, 4);
    chk(accv, 8'h99);
    run(OPC_A_IND | 1, 8'h00, 8'h00, 4);
    chk(accv, 8'h77);
    chk(n_re, 2);
    run(OPC_A_IMM, 8'h3c, 8'h00, 2);
    chk(accv, 8'h3c);
    chk(len, LEN_2);
    chk(n_re, 0);
    run(OPC_A_DIR, 8'h35, 8'h00, 3);
    chk(accv, 8'ha5);
    chk(ram[8'h35], 8'ha5);
    chk(n_we, 0);
    $display("work register test done");
  endtask : t_acc

  task automatic t_dst;
    bank = 2'h1; acc = 8'hc1;
    ram[8'h30] = 8'h5a; ram[8'h09] = 8'h50; ram[8'h0a] = 8'h2b;
    ram[8'h08] = 8'h30;
    mv(OPC_R_A | 3, 8'h00, 8'h00, 2, 8'h0b, 8'hc1);
    mv(OPC_R_DIR | 5, 8'h30, 8'h00, 3, 8'h0d, 8'h5a);
    mv(OPC_R_IMM | 7, 8'he7, 8'h00, 2, 8'h0f, 8'he7);
    mv(OPC_I_A | 1, 8'h00, 8'h00, 3, 8'h50, 8'hc1);
    mv(OPC_I_IMM | 1, 8'h6e, 8'h00, 3, 8'h50, 8'h6e);
    mv(OPC_I_DIR | 1, 8'h30, 8'h00, 4, 8'h50, 8'h5a);
    mv(OPC_D_A, 8'h60, 8'h00, 2, 8'h60, 8'hc1);
    mv(OPC_D_REG | 2, 8'h61, 8'h00, 3, 8'h61, 8'h2b);
    mv(OPC_D_IND, 8'h62, 8'h00, 4, 8'h62, 8'h5a);
    mv(OPC_D_DIR, 8'h30, 8'h63, 3, 8'h63, 8'h5a);
    mv(OPC_D_IMM, 8'h64, 8'h4d, 2, 8'h64, 8'h4d);
    chk(len, LEN_3);
    chk(n_re, 0);
    chk(ram[8'h30], 8'h5a);
    $display("destination test done");
  endtask : t_dst

  task automatic t_odd;
    run(OPC_A_DIR, 8'he0, 8'h00, 1);
    chk(strb, 5'b10000);
    chk(n_we, 0);
    ram[8'h21] = 8'h08; ram[8'h90] = 8'hf0;
    bitop(8'h0b, 1'b1, 1'b0, 2);
    chk({strb, cv}, 6'b000011);
    bitop(8'h0b, 1'b0, 1'b0, 3);
    chk(ram[8'h21], 8'h00);
    bitop(8'h93, 1'b0, 1'b1, 3);
    chk(ram[8'h90], 8'hf8);
    bitop(8'h97, 1'b1, 1'b0, 2);
    chk(cv, 1'b1);
    $display("illegal and bit test done");
  endtask : t_odd

  // ==========================================================================
  // Verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    for (int a = 0; a < 256; a++) ram[a] = 8'h00;
    repeat (12) @(posedge i_clock);
    #2 i_sys_rst = 1'b0;
    chk({busy, done, ill}, 3'b000);
    t_branch();
    t_acc();
    t_dst();
    t_odd();
    finish_test();
  end

  // Watchdog: the tests need about 150 cycles, this allows 4000
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule : test_long_branch_and_byte_move_exec
